/* File: rtl/station_filter_pkg.sv */
// Shared constants and types for the station address filter
package station_filter_pkg;

   // ---------------------------------------------
   // Line timing
   // ---------------------------------------------
   localparam int          CLK_HZ      = 100000000;
   localparam int          BAUD_BPS    = 9600;
   localparam int          CNT_W       = 16;
   // Longest whole bit time in clock cycles, rounded down
   localparam logic [15:0] BIT_CYCLES  = 16'(CLK_HZ / BAUD_BPS);
   localparam logic [15:0] HALF_CYCLES = 16'(CLK_HZ / BAUD_BPS / 2);
   localparam logic [2:0]  LAST_BIT    = 3'h7;

   // ---------------------------------------------
   // Addressing
   // ---------------------------------------------
   localparam logic [7:0] ADDR_OFFSET  = 8'h40;
   localparam logic [2:0] ADDR_HIGH    = 3'h2;
   localparam logic [4:0] ADDR_ANY     = 5'h00;
   localparam logic [4:0] ADDR_BCAST   = 5'h1F;
   localparam logic [4:0] STATION_MIN  = 5'h01;
   localparam logic [4:0] STATION_MAX  = 5'h1E;
   // Character that opens a telegram; the next one is the address
   localparam logic [7:0] START_CHAR   = 8'h04;

   // ---------------------------------------------
   // Types
   // ---------------------------------------------
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_type;
   typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_type;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } char_type;

   typedef struct packed {
      logic addr_valid;
      logic match;
      logic any;
      logic bcast;
      logic reply_ok;
   } addr_flags_type;

   typedef struct packed {
      rx_state_type   rx_state;
      logic [15:0]    rx_cnt;
      logic [2:0]     rx_bit;
      logic [7:0]     rx_shift;
      tx_state_type   tx_state;
      logic [15:0]    tx_cnt;
      logic [2:0]     tx_bit;
      logic [7:0]     tx_shift;
      logic           tx_line;
      logic           rts;
      logic           expect_addr;
      char_type       rx_char;
      addr_flags_type flags;
   } state_type;

endpackage

/* File: rtl/station_filter.sv */
// Station address filter with serial receiver and reply transmitter
//
// Contract
// - Own station number valid only from 1 to 30
// - Address 0 accepted whatever the station number
// - Address 31 accepted, never answered
// - Address character equals address plus 40h
// - Characters run at 9600 bit/s, slave only answers
`timescale 1ns/1ps

module station_filter
#(
   parameter logic [15:0] BIT_CYCLES  = station_filter_pkg::BIT_CYCLES,
   parameter logic [15:0] HALF_CYCLES = station_filter_pkg::HALF_CYCLES
)
(
   // Clock and reset
   input  wire logic                                i_clk,
   input  wire logic                                i_reset,
   // Configuration
   input  wire logic [4:0]                          i_station,
   // Serial line
   input  wire logic                                i_rx_line,
   output      logic                                o_tx_line,
   output      logic                                o_rts,
   // Received characters
   output      station_filter_pkg::char_type        o_rx_char,
   // Address decision
   output      station_filter_pkg::addr_flags_type  o_addr,
   // Reply characters
   input  wire station_filter_pkg::char_type        i_tx_char,
   output      logic                                o_tx_ready
);

   station_filter_pkg::state_type s_q;
   station_filter_pkg::state_type s_d;

   // ------------------------------------------------
   // Address decoding
   // ------------------------------------------------

   // Valid address characters lie between '@' and '_'
   function automatic logic is_addr_char(input logic [7:0] c);
      is_addr_char = (c[7:5] == station_filter_pkg::ADDR_HIGH);
   endfunction

   // Own station only counts when it lies in the legal range
   function automatic logic station_ok(input logic [4:0] st);
      station_ok = (st >= station_filter_pkg::STATION_MIN) &&
                   (st <= station_filter_pkg::STATION_MAX);
   endfunction

   // ------------------------------------------------
   // Next state
   // ------------------------------------------------

   // One process carries receiver, decision and transmitter
   always_comb
   begin
      logic [4:0] addr;
      logic       got_char;
      addr          = 5'h00;
      got_char      = 1'b0;
      s_d           = s_q;
      s_d.rx_char.valid    = 1'b0;
      s_d.flags.addr_valid = 1'b0;

      // Receiver, mid-bit sampling at the line rate
      case (s_q.rx_state)
         station_filter_pkg::RX_IDLE:
         begin
            s_d.rx_cnt = 16'h0000;
            if (!i_rx_line)
            begin
               s_d.rx_state = station_filter_pkg::RX_START;
            end
         end
         station_filter_pkg::RX_START:
         begin
            s_d.rx_cnt = s_q.rx_cnt + 16'h0001;
            if (s_q.rx_cnt == HALF_CYCLES - 16'h0001)
            begin
               s_d.rx_cnt = 16'h0000;
               s_d.rx_bit = 3'h0;
               // A glitch shorter than half a bit is not a start
               s_d.rx_state = i_rx_line ? station_filter_pkg::RX_IDLE
                                        : station_filter_pkg::RX_DATA;
            end
         end
         station_filter_pkg::RX_DATA:
         begin
            s_d.rx_cnt = s_q.rx_cnt + 16'h0001;
            if (s_q.rx_cnt == BIT_CYCLES - 16'h0001)
            begin
               s_d.rx_cnt   = 16'h0000;
               s_d.rx_shift = {i_rx_line, s_q.rx_shift[7:1]};
               s_d.rx_bit   = s_q.rx_bit + 3'h1;
               if (s_q.rx_bit == station_filter_pkg::LAST_BIT)
               begin
                  s_d.rx_state = station_filter_pkg::RX_STOP;
               end
            end
         end
         station_filter_pkg::RX_STOP:
         begin
            s_d.rx_cnt = s_q.rx_cnt + 16'h0001;
            if (s_q.rx_cnt >= BIT_CYCLES - 16'h0001)
            begin
               // Hold at mark wait, so a low stop bit is never taken as a start
               s_d.rx_cnt = BIT_CYCLES;
               if (i_rx_line)
               begin
                  s_d.rx_state = station_filter_pkg::RX_IDLE;
               end
               // Framing errors drop the character silently
               got_char = i_rx_line && (s_q.rx_cnt == BIT_CYCLES - 16'h0001);
            end
         end
         default:
         begin
            s_d.rx_state = station_filter_pkg::RX_IDLE;
         end
      endcase

      // Address decision on the character after the opener
      if (got_char)
      begin
         s_d.rx_char.valid = 1'b1;
         s_d.rx_char.data  = s_q.rx_shift;
         if (s_q.rx_shift == station_filter_pkg::START_CHAR)
         begin
            // New telegram withdraws permission to answer
            s_d.expect_addr    = 1'b1;
            s_d.flags.match    = 1'b0;
            s_d.flags.any      = 1'b0;
            s_d.flags.bcast    = 1'b0;
            s_d.flags.reply_ok = 1'b0;
         end
         else if (s_q.expect_addr)
         begin
            s_d.expect_addr = 1'b0;
            if (is_addr_char(s_q.rx_shift))
            begin
               addr = s_q.rx_shift[4:0] - station_filter_pkg::ADDR_OFFSET[4:0];
               s_d.flags.addr_valid = 1'b1;
               s_d.flags.any   = (addr == station_filter_pkg::ADDR_ANY);
               s_d.flags.bcast = (addr == station_filter_pkg::ADDR_BCAST);
               s_d.flags.match = station_ok(i_station) && (addr == i_station);
               // Broadcast is acted on but never answered
               s_d.flags.reply_ok = s_d.flags.any || s_d.flags.match;
            end
         end
      end

      // Transmitter, only ever in answer to an accepted telegram
      case (s_q.tx_state)
         station_filter_pkg::TX_IDLE:
         begin
            s_d.tx_line = 1'b1;
            s_d.tx_cnt  = 16'h0000;
            if (i_tx_char.valid && o_tx_ready)
            begin
               s_d.tx_shift = i_tx_char.data;
               s_d.tx_line  = 1'b0;
               s_d.tx_state = station_filter_pkg::TX_START;
            end
         end
         station_filter_pkg::TX_START:
         begin
            s_d.tx_cnt = s_q.tx_cnt + 16'h0001;
            if (s_q.tx_cnt == BIT_CYCLES - 16'h0001)
            begin
               s_d.tx_cnt   = 16'h0000;
               s_d.tx_bit   = 3'h0;
               s_d.tx_line  = s_q.tx_shift[0];
               s_d.tx_state = station_filter_pkg::TX_DATA;
            end
         end
         station_filter_pkg::TX_DATA:
         begin
            s_d.tx_cnt = s_q.tx_cnt + 16'h0001;
            if (s_q.tx_cnt == BIT_CYCLES - 16'h0001)
            begin
               s_d.tx_cnt   = 16'h0000;
               s_d.tx_bit   = s_q.tx_bit + 3'h1;
               s_d.tx_shift = {1'b1, s_q.tx_shift[7:1]};
               s_d.tx_line  = s_q.tx_shift[1];
               if (s_q.tx_bit == station_filter_pkg::LAST_BIT)
               begin
                  s_d.tx_line  = 1'b1;
                  s_d.tx_state = station_filter_pkg::TX_STOP;
               end
            end
         end
         station_filter_pkg::TX_STOP:
         begin
            s_d.tx_cnt = s_q.tx_cnt + 16'h0001;
            if (s_q.tx_cnt == BIT_CYCLES - 16'h0001)
            begin
               s_d.tx_state = station_filter_pkg::TX_IDLE;
            end
         end
         default:
         begin
            s_d.tx_state = station_filter_pkg::TX_IDLE;
         end
      endcase

      // Direction held only across a character in flight
      s_d.rts = (s_d.tx_state != station_filter_pkg::TX_IDLE);
   end

   // ------------------------------------------------
   // State register
   // ------------------------------------------------

   // Synchronous reset leaves the line idle and released
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         s_q          <= '0;
         s_q.rx_state <= station_filter_pkg::RX_IDLE;
         s_q.tx_state <= station_filter_pkg::TX_IDLE;
         s_q.tx_line  <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------
   // Outputs
   // ------------------------------------------------

   // Ready is combinational; data all from flip-flops
   assign o_tx_ready = (s_q.tx_state == station_filter_pkg::TX_IDLE) &&
                       s_q.flags.reply_ok && !s_q.flags.bcast;
   assign o_tx_line  = s_q.tx_line;
   assign o_rts      = s_q.rts;
   assign o_rx_char  = s_q.rx_char;
   assign o_addr     = s_q.flags;

   // ------------------------------------------------
   // Assertions
   // ------------------------------------------------

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   a_station_range: assert property (
      o_addr.addr_valid && o_addr.match |->
         ($past(i_station) >= 5'h01) && ($past(i_station) <= 5'h1E))
      else $error("Match reported for station out of range");

   a_any_station: assert property (
      o_addr.addr_valid && $past(s_q.rx_shift) == 8'h40 |->
         o_addr.any && o_addr.reply_ok)
      else $error("Address 0 not accepted");

   a_bcast_silent: assert property (
      o_addr.bcast && s_q.tx_state == station_filter_pkg::TX_IDLE |=> !o_rts [*2])
      else $error("Transmission started after broadcast");

   a_addr_offset: assert property (
      o_addr.addr_valid && o_addr.bcast |-> $past(s_q.rx_shift) == 8'h5F)
      else $error("Broadcast decoded from wrong character");

   a_bit_period: assert property (
      $changed(s_q.tx_bit) && s_q.tx_state != station_filter_pkg::TX_IDLE |->
         $past(s_q.tx_cnt) == BIT_CYCLES - 16'h0001)
      else $error("Transmit bit shorter or longer than one bit time");

   a_rts_covers: assert property (
      !o_tx_line |-> o_rts)
      else $error("Line driven low without request-to-send");

   a_rts_release: assert property (
      s_q.tx_state == station_filter_pkg::TX_STOP &&
      s_q.tx_cnt == BIT_CYCLES - 16'h0001 |=> !o_rts)
      else $error("Request-to-send not released after stop bit");

   a_no_stray_reply: assert property (
      $rose(o_rts) |-> $past(o_tx_ready))
      else $error("Reply started without permission");

   c_any_addr:  cover property (o_addr.addr_valid && o_addr.any);
   c_bcast:     cover property (o_addr.addr_valid && o_addr.bcast);
   c_own_reply: cover property (o_addr.match ##1 $rose(o_rts));

endmodule

/* File: testbench/station_master_model.sv */
// Network master model: sends telegram characters and reads replies
`timescale 1ns/1ps

module station_master_model
#(
   parameter int BIT = 16
)
(
   // Clock
   input  wire logic i_clk,
   // Serial line
   output      logic o_line,
   output      logic o_master_rts,
   input  wire logic i_tx_line,
   input  wire logic i_rts
);
   // ---------------------------------------------
   // Line idles at mark level
   // ---------------------------------------------
   initial
   begin
      o_line       = 1'b1;
      o_master_rts = 1'b0;
   end

   // One 8N1 character, LSB first
   task automatic send_char(input logic [7:0] c, input logic stop);
      logic [9:0] frame;
      frame        = {stop, c, 1'b0};
      o_master_rts = 1'b1;  // Converter direction held for the frame
      for (int i = 0; i < 10; i++)
      begin
         @(negedge i_clk);
         o_line = frame[i];
         repeat (BIT - 1) @(negedge i_clk);
      end
      @(negedge i_clk);
      o_line       = 1'b1;
      o_master_rts = 1'b0;
      repeat (BIT) @(negedge i_clk);
   endtask

   // Reply reader; samples mid-bit so edge jitter of a cycle is harmless
   task automatic recv_char(output logic [7:0] c, output logic ok, output logic rts_ok);
      int n;
      n      = 0;
      ok     = 1'b0;
      rts_ok = 1'b1;
      c      = 8'h00;
      while (i_tx_line !== 1'b0 && n < 4 * BIT)
      begin
         @(negedge i_clk);
         n++;
      end
      if (n < 4 * BIT)
      begin
         repeat (BIT / 2) @(negedge i_clk);
         for (int i = 0; i < 8; i++)
         begin
            repeat (BIT) @(negedge i_clk);
            c[i]   = i_tx_line;
            rts_ok = rts_ok & (i_rts === 1'b1);
         end
         repeat (BIT) @(negedge i_clk);
         ok = (i_tx_line === 1'b1);
      end
   endtask
endmodule

/* File: testbench/tb_station_filter.sv */
// Testbench for the station address filter
`timescale 1ns/1ps

module tb_station_filter;
   localparam int BIT = 16;
   logic                               clk;
   logic                               reset;
   logic [4:0]                         station;
   logic                               rx_line;
   logic                               tx_line;
   logic                               rts;
   logic                               tx_ready;
   station_filter_pkg::char_type       rx_char;
   station_filter_pkg::char_type       tx_char;
   station_filter_pkg::addr_flags_type addr;
   int                                 mismatches;
   int                                 n_checks;
   int                                 n_addr;
   int                                 n_rx;

   station_filter #(.BIT_CYCLES(16'h0010), .HALF_CYCLES(16'h0008)) i_station_filter (
      .i_clk(clk), .i_reset(reset), .i_station(station), .i_rx_line(rx_line),
      .o_tx_line(tx_line), .o_rts(rts), .o_rx_char(rx_char), .o_addr(addr),
      .i_tx_char(tx_char), .o_tx_ready(tx_ready));

   station_master_model #(.BIT(BIT)) i_station_master_model (
      .i_clk(clk), .o_line(rx_line), .o_master_rts(), .i_tx_line(tx_line), .i_rts(rts));

   // ---------------------------------------------
   // Clock and pulse counters
   // ---------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Pulses last one cycle, so count them rather than poll
   always @(posedge clk)
   begin
      if (addr.addr_valid === 1'b1) n_addr++;
      if (rx_char.valid === 1'b1) n_rx++;
   end

   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] expected);
      n_checks++;
      if (seen !== expected)
      begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%0h expected=%0h", $time, seen, expected);
      end
   endtask

   task automatic close_out;
      $display("checks=%0d mismatches=%0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic send_tel(input logic [4:0] a);
      i_station_master_model.send_char(8'h04, 1'b1);
      i_station_master_model.send_char({3'h2, a}, 1'b1);
   endtask

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic test_reset;
      check({tx_line, rts, addr, tx_ready}, {1'b1, 1'b0, 5'h00, 1'b0});
      $display("test_reset done");
   endtask

   // Every address, against own and a neighbouring station number
   task automatic test_addresses;
      int   na;
      logic m;
      logic r;
      for (int a = 0; a < 32; a++)
         for (int k = 0; k < 2; k++)
         begin
            @(negedge clk);
            station = 5'(a + k);
            na      = n_addr;
            send_tel(5'(a)); // One slave only, so address 0 is legal
            m = (k == 0) && (a >= 1) && (a <= 30);
            r = m || (a == 0);
            check(n_addr - na, 1);
            check(rx_char.data, {3'h2, 5'(a)});
            check(addr, {1'b0, m, a == 0, a == 31, r});
            check(tx_ready, r);
         end
      $display("test_addresses done");
   endtask

   // Reply after own address, then a new opener refuses further replies
   task automatic test_reply;
      logic [7:0] c;
      logic       ok;
      logic       rts_ok;
      @(negedge clk);
      station = 5'h07;
      send_tel(5'h07);
      tx_char = {1'b1, 8'hA5};
      @(negedge clk);
      tx_char.valid = 1'b0;
      check({rts, tx_line, tx_ready}, 3'b100);
      i_station_master_model.recv_char(c, ok, rts_ok);
      // A missing or misframed reply counts here and the run goes on
      check(ok, 1'b1);
      check(c, 8'hA5);
      check(rts_ok, 1'b1);
      repeat (BIT) @(negedge clk);
      check({rts, tx_line}, 2'b01);
      i_station_master_model.send_char(8'h04, 1'b1);
      check({addr, tx_ready}, 6'h00);
      $display("test_reply done");
   endtask

   // Framing error dropped; non-address character after opener ignored
   task automatic test_bad_chars;
      int nr;
      int na;
      nr = n_rx;
      na = n_addr;
      i_station_master_model.send_char(8'h04, 1'b1);
      i_station_master_model.send_char(8'h47, 1'b0);
      check(n_rx - nr, 1);
      i_station_master_model.send_char(8'h30, 1'b1);
      check(n_rx - nr, 2);
      check(n_addr - na, 0);
      check(addr, 5'h00);
      $display("test_bad_chars done");
   endtask

   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial
   begin
      mismatches = 0;
      n_checks   = 0;
      n_addr     = 0;
      n_rx       = 0;
      reset      = 1'b1;
      station    = 5'h01;
      tx_char    = '0;
      repeat (8) @(negedge clk);
      reset = 1'b0;
      test_reset();
      test_addresses();
      test_reply();
      test_bad_chars();
      close_out();
   end
endmodule
